// ---- rtl/aclc_link.sv ----
// Purpose: serial link controller for one or two audio/modem codecs
// Assumes: bit clock from the primary codec, sampled by core_clk
// Notes: 12 slots each way, 256 bit frames, sync on bit 0..15
`include "aclc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - every frame carries twelve slots outbound and twelve slots inbound
// - streams and codec register accesses share the slotted frames in order
// - at most two codecs, each with its own return data line
// - bit clock launches outgoing data and samples incoming data
// - codec raising its return line during shut-off raises a wake event
// - weak keeper pulls enabled only while the shut-off bit is set
// - link on: codec drives bit clock, controller drives serial out
// - in 4 or 6 channel mode hold samples until all requests set
// - controller drives the active-low link reset to the codecs
module aclc_link #(
	parameter int SLOT_W = `ACLC_SLOT_W
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic link_bit_clk,
	output logic link_serial_out,
	output logic link_sync,
	output logic link_reset_n,
	input wire logic link_serial_return_first,
	input wire logic link_serial_return_second,
	input wire logic board_codec_disable_n,
	output logic link_keeper_en
);

	// ******************************
	// pin synchronisers
	// ******************************
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic bclk_q;
	logic [1:0] ret_q;
	logic board_q;
	always_ff @(posedge core_clk) begin
		sync_a <= {board_codec_disable_n, link_serial_return_second,
			link_serial_return_first};
		sync_b <= sync_a;
	end
	logic bclk_a;
	logic bclk_b;
	always_ff @(posedge core_clk) begin
		bclk_a <= link_bit_clk;
		bclk_b <= bclk_a;
		bclk_q <= bclk_b;
	end
	assign ret_q = sync_b[1:0];
	assign board_q = sync_b[2];
	// edges of the sampled bit clock; launch on rise, capture on fall
	logic bclk_rise;
	logic bclk_fall;
	assign bclk_rise = bclk_b & ~bclk_q;
	assign bclk_fall = ~bclk_b & bclk_q;

	// ******************************
	// control registers
	// ******************************
	logic [3:0] ctrl;
	logic [SLOT_W-1:0] out_data;
	logic [`ACLC_INT_W-1:0] int_en;
	logic shutoff;
	assign shutoff = ctrl[`ACLC_CTRL_SHUTOFF];
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl <= `ACLC_CTRL_RESET;
			int_en <= '0;
			out_data <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
			`ACLC_REG_CTRL: ctrl <= reg_wdata[3:0];
			`ACLC_REG_INT_EN: int_en <= reg_wdata[`ACLC_INT_W-1:0];
			`ACLC_REG_OUT_DATA: out_data <= reg_wdata[SLOT_W-1:0];
			default: ;
			endcase
		end
	end
	aclc_pkg::aclc_chan_t chan;
	assign chan = aclc_pkg::aclc_chan_t'(
		ctrl[`ACLC_CTRL_CH_HI:`ACLC_CTRL_CH_LO]);

	// ******************************
	// frame state
	// ******************************
	aclc_pkg::aclc_state_t state;
	aclc_pkg::aclc_state_t next_state;
	logic [7:0] bit_cnt;
	logic frame_end;
	assign frame_end = bclk_rise && (bit_cnt == 8'hff);
	always_comb begin
		next_state = state;
		case (state)
		aclc_pkg::ACLC_OFF:
			if (!shutoff && ctrl[`ACLC_CTRL_RESET_N])
				next_state = aclc_pkg::ACLC_WAIT;
		aclc_pkg::ACLC_WAIT:
			if (shutoff)
				next_state = aclc_pkg::ACLC_OFF;
			else if (bclk_rise)
				next_state = aclc_pkg::ACLC_RUN;
		aclc_pkg::ACLC_RUN:
			if (shutoff || !ctrl[`ACLC_CTRL_RESET_N])
				next_state = aclc_pkg::ACLC_OFF;
		default: next_state = aclc_pkg::ACLC_OFF;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			state <= aclc_pkg::ACLC_OFF;
		else
			state <= next_state;
	end
	logic running;
	assign running = (state == aclc_pkg::ACLC_RUN);

	// bit counter within the 256 bit frame
	always_ff @(posedge core_clk) begin
		if (srst || !running)
			bit_cnt <= '0;
		else if (bclk_rise)
			bit_cnt <= bit_cnt + 8'h01;
	end

	// slot index from bit position: tag 16 bits, then 20 bit slots
	function automatic logic [3:0] slot_of(input logic [7:0] b);
		logic [7:0] d;
		d = b - 8'd16;
		if (b < 8'd16)
			slot_of = 4'h0;
		else
			slot_of = 4'(d / 8'd20 + 8'd1);
	endfunction
	function automatic logic [4:0] pos_of(input logic [7:0] b);
		logic [7:0] d;
		d = b - 8'd16;
		if (b < 8'd16)
			pos_of = 5'(b);
		else
			pos_of = 5'(d % 8'd20);
	endfunction

	// ******************************
	// inbound frame capture
	// ******************************
	// return bits lag two bit clocks: codec sees sync on a fall, answers
	// on the next rise, so inbound positions trail the launch counter
	logic [7:0] rx_pos;
	assign rx_pos = bit_cnt - 8'd2;
	logic [15:0] tag_in [2];
	logic [1:0] req_ok;
	logic [SLOT_W-1:0] rx_shift;
	logic [SLOT_W-1:0] rx_word;
	logic rx_evt;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_tag
			always_ff @(posedge core_clk) begin
				if (srst || !running)
					tag_in[g] <= '0;
				else if (bclk_fall && slot_of(rx_pos) == 4'h0)
					tag_in[g] <= {tag_in[g][14:0], ret_q[g]};
			end
		end
	endgenerate
	// an absent codec never sets its ready bit, so its slots stay invalid
	logic [1:0] codec_ok;
	assign codec_ok = {tag_in[1][15], tag_in[0][15]};
	// slot requests are the codec ready bits (tag bit 15): both codecs in 4 and 6 channel mode, the first otherwise
	always_comb begin
		case (chan)
		aclc_pkg::ACLC_CH4,
		aclc_pkg::ACLC_CH6:
			req_ok = codec_ok;
		default:
			req_ok = {1'b1, codec_ok[0]};
		endcase
	end
	logic send_ok;
	always_ff @(posedge core_clk) begin
		if (srst || !running)
			send_ok <= 1'b0;
		else if (frame_end)
			send_ok <= &req_ok;
	end
	always_ff @(posedge core_clk) begin
		if (srst || !running) begin
			rx_shift <= '0;
			rx_word <= '0;
			rx_evt <= 1'b0;
		end else begin
			rx_evt <= 1'b0;
			if (bclk_fall && slot_of(rx_pos) == 4'h3 && codec_ok[0]) begin
				rx_shift <= {rx_shift[SLOT_W-2:0], ret_q[0]};
				if (pos_of(rx_pos) == 5'(SLOT_W - 1)) begin
					rx_word <= {rx_shift[SLOT_W-2:0], ret_q[0]};
					rx_evt <= 1'b1;
				end
			end
		end
	end

	// ******************************
	// outbound frame launch
	// ******************************
	logic tx_bit;
	always_comb begin
		tx_bit = 1'b0;
		if (slot_of(bit_cnt) == 4'h0)
			tx_bit = (bit_cnt == 8'h00) ? send_ok : 1'b0;
		else if (slot_of(bit_cnt) >= 4'h3 && send_ok)
			tx_bit = out_data[5'(SLOT_W - 1) - pos_of(bit_cnt)];
	end
	always_ff @(posedge core_clk) begin
		if (srst || !running) begin
			link_serial_out <= 1'b0;
			link_sync <= 1'b0;
		end else if (bclk_rise) begin
			link_serial_out <= tx_bit;
			link_sync <= (bit_cnt < 8'd16);
		end
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			link_reset_n <= 1'b0;
		else
			link_reset_n <= ctrl[`ACLC_CTRL_RESET_N];
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			link_keeper_en <= 1'b1;
		else
			link_keeper_en <= shutoff;
	end

	// ******************************
	// events and interrupt
	// ******************************
	logic wake_evt;
	logic [1:0] ret_d;
	always_ff @(posedge core_clk) begin
		if (srst)
			ret_d <= '0;
		else
			ret_d <= ret_q;
	end
	// a line held low by the keeper never wakes
	assign wake_evt = shutoff && |(ret_q & ~ret_d);
	logic [`ACLC_INT_W-1:0] int_stat;
	logic [`ACLC_INT_W-1:0] int_set;
	logic [`ACLC_INT_W-1:0] int_clr;
	assign int_set = {rx_evt, wake_evt, frame_end && running};
	assign int_clr = (reg_wr && reg_addr == `ACLC_REG_INT_CLR) ?
		reg_wdata[`ACLC_INT_W-1:0] : '0;
	always_ff @(posedge core_clk) begin
		if (srst)
			int_stat <= '0;
		else
			int_stat <= (int_stat & ~int_clr) | int_set; // set wins
	end
	always_ff @(posedge core_clk) begin
		if (srst)
			irq <= 1'b0;
		else
			irq <= |(((int_stat & ~int_clr) | int_set) & int_en);
	end

	// ******************************
	// register read
	// ******************************
	always_ff @(posedge core_clk) begin
		if (srst)
			reg_rdata <= '0;
		else if (reg_rd) begin
			case (reg_addr)
			`ACLC_REG_CTRL: reg_rdata <= {28'h000_0000, ctrl};
			`ACLC_REG_STATUS: reg_rdata <= {24'h00_0000, 1'b0, send_ok,
				board_q, codec_ok, state};
			`ACLC_REG_INT_STAT: reg_rdata <= {29'h000_0000, int_stat};
			`ACLC_REG_INT_EN: reg_rdata <= {29'h000_0000, int_en};
			`ACLC_REG_OUT_DATA: reg_rdata <= 32'(out_data);
			`ACLC_REG_IN_DATA: reg_rdata <= 32'(rx_word);
			default: reg_rdata <= 32'h0000_0000;
			endcase
		end else
			reg_rdata <= 32'h0000_0000;
	end

	// ******************************
	// checks
	// ******************************
	sequence frame_wrap_s;
		running && frame_end;
	endsequence
	keeper_follow_a: assert property (@(posedge core_clk) disable iff (srst)
		shutoff |=> link_keeper_en)
		else $error("keeper not on in shut-off");
	reset_drive_a: assert property (@(posedge core_clk) disable iff (srst)
		!ctrl[`ACLC_CTRL_RESET_N] |=> !link_reset_n)
		else $error("link reset not asserted");
	hold_data_a: assert property (@(posedge core_clk) disable iff (srst)
		!send_ok && bclk_rise && slot_of(bit_cnt) >= 4'h3 |=>
		!link_serial_out)
		else $error("samples sent before requests");
	wake_flag_a: assert property (@(posedge core_clk) disable iff (srst)
		wake_evt |=> int_stat[`ACLC_INT_WAKE])
		else $error("wake not latched");
	no_wake_on_a: assert property (@(posedge core_clk) disable iff (srst)
		!shutoff |-> !wake_evt)
		else $error("wake while link on");
	frame_cnt_a: assert property (@(posedge core_clk) disable iff (srst)
		frame_wrap_s |=> bit_cnt == 8'h00)
		else $error("frame not 256 bits");
	off_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
		!running |=> !link_sync)
		else $error("sync driven while off");
	sync_tag_a: assert property (@(posedge core_clk) disable iff (srst)
		running && bclk_rise && bit_cnt == 8'd20 |=> !link_sync)
		else $error("sync past tag slot");
	rx_gate_a: assert property (@(posedge core_clk) disable iff (srst)
		!codec_ok[0] |=> !rx_evt)
		else $error("slot word from absent codec");

endmodule
`default_nettype wire

// ---- rtl/aclc_pkg.sv ----
// Purpose: shared types of the link controller
// Assumes: nothing
// Notes: states are one-hot
package aclc_pkg;
	typedef enum logic [2:0] {
		ACLC_OFF = 3'b001,
		ACLC_WAIT = 3'b010,
		ACLC_RUN = 3'b100
	} aclc_state_t;
	typedef enum logic [1:0] {
		ACLC_CH2 = 2'b00,
		ACLC_CH4 = 2'b01,
		ACLC_CH6 = 2'b10
	} aclc_chan_t;
endpackage

// ---- rtl/aclc_regs.svh ----
// Purpose: register offsets, fields and timing counts of the link controller
// Assumes: word-indexed plain register port
// Notes: definitions only
`ifndef ACLC_REGS_SVH
`define ACLC_REGS_SVH

// ******************************
// register offsets
// ******************************
`define ACLC_REG_CTRL 4'h0
`define ACLC_REG_STATUS 4'h1
`define ACLC_REG_INT_STAT 4'h2
`define ACLC_REG_INT_EN 4'h3
`define ACLC_REG_INT_CLR 4'h4
`define ACLC_REG_OUT_DATA 4'h5
`define ACLC_REG_IN_DATA 4'h6

// ******************************
// control fields
// ******************************
`define ACLC_CTRL_SHUTOFF 0
`define ACLC_CTRL_RESET_N 1
`define ACLC_CTRL_CH_LO 2
`define ACLC_CTRL_CH_HI 3
`define ACLC_CTRL_RESET 4'h1

// ******************************
// interrupt fields
// ******************************
`define ACLC_INT_FRAME 0
`define ACLC_INT_WAKE 1
`define ACLC_INT_RX 2
`define ACLC_INT_W 3

// ******************************
// frame geometry
// ******************************
`define ACLC_SLOTS 12
`define ACLC_TAG_BITS 16
`define ACLC_SLOT_BITS 20
`define ACLC_FRAME_BITS 9'h100
`define ACLC_SLOT_W 20

`endif

// ---- test/aclc_codec_model.sv ----
// Purpose: behavioural codec on the far side of the serial link
// Assumes: bit clock of 400 ns, stopped while the link is off
// Notes: drives tag and slot 3 msb first on bit clock rise
`timescale 1ns/1ps
`default_nettype none
module aclc_codec_model #(
	parameter logic [19:0] SLOT3 = 20'h5_a3c1
) (
	input wire logic clk_en,
	input wire logic ready,
	input wire logic wake,
	input wire logic link_sync,
	input wire logic link_reset_n,
	output logic bit_clk,
	output logic sdin
);
	int pos = 300;
	logic sync_q = 1'b0;
	logic drv = 1'b0;
	initial bit_clk = 1'b0;
	// ***
	// clock and framing
	// ***
	always #200 bit_clk = clk_en ? ~bit_clk : 1'b0;
	always @(negedge bit_clk) begin
		if (link_sync && !sync_q) pos = 0;
		else pos = pos + 1;
		sync_q = link_sync;
	end
	// tag bit15 ready, bit12 slot 3 valid
	always @(posedge bit_clk) begin
		if (!link_reset_n) drv <= 1'b0;
		else if (pos == 0 || pos == 3) drv <= ready;
		else if (pos >= 56 && pos < 76) drv <= SLOT3[75-pos];
		else drv <= 1'b0;
	end
	// idle line sits on the keeper pull-down unless waking
	assign sdin = clk_en ? drv : wake;
endmodule
`default_nettype wire

// ---- test/aclc_link_tb_top.sv ----
// Purpose: self-checking bench of the link controller
// Assumes: one codec present, second return line pulled low
// Notes: register rows first, then link, irq and wake cases
`timescale 1ns/1ps
`default_nettype none
module aclc_link_tb_top;
	typedef struct packed {
		logic w;
		logic [3:0] a;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} aclc_row_t;
	logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, irq, clk_en = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
	logic link_bit_clk, link_serial_out, link_sync, link_reset_n;
	logic sdin0, board_codec_disable_n = 1, link_keeper_en, wake = 0;
	logic sync_q = 0;
	logic [31:0] pos = 0, hi = 0, frame_len = 0, hi_len = 0;
	logic [19:0] cap = 0, slot_cap = 0;
	int bad_count = 0, n_checks = 0;
	aclc_row_t rows[10] = '{
		'{0, 4'h0, 0, 32'hffff_ffff, 32'h0000_0001},
		'{0, 4'h1, 0, 32'h0000_003f, 32'h0000_0021},
		'{0, 4'h2, 0, 32'hffff_ffff, 32'h0000_0000},
		'{0, 4'h3, 0, 32'hffff_ffff, 32'h0000_0000},
		'{1, 4'h3, 32'h0000_0007, 32'hffff_ffff, 32'h0000_0007},
		'{1, 4'h4, 32'h0000_0007, 32'hffff_ffff, 32'h0000_0000},
		'{1, 4'h7, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_0000},
		'{1, 4'h1, 32'hffff_ffff, 32'h0000_003f, 32'h0000_0021},
		'{1, 4'h0, 32'h0000_0009, 32'hffff_ffff, 32'h0000_0009},
		'{1, 4'h5, 32'hffff_ffff, 32'h000f_ffff, 32'h000f_ffff}};
	aclc_link i_aclc_link (.core_clk(core_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.link_bit_clk(link_bit_clk), .link_serial_out(link_serial_out),
		.link_sync(link_sync), .link_reset_n(link_reset_n),
		.link_serial_return_first(sdin0),
		.link_serial_return_second(1'b0),
		.board_codec_disable_n(board_codec_disable_n),
		.link_keeper_en(link_keeper_en));
	// lone audio primary: an allowed population
	aclc_codec_model i_aclc_codec_model (.clk_en(clk_en), .ready(1'b1),
		.wake(wake), .link_sync(link_sync), .link_reset_n(link_reset_n),
		.bit_clk(link_bit_clk), .sdin(sdin0));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	// sampled on the next rise, while the bit still stands
	always @(posedge link_bit_clk) begin
		if (link_sync && !sync_q) begin
			frame_len <= pos;
			hi_len <= hi;
			slot_cap <= cap;
			pos <= 1;
			hi <= 1;
		end else begin
			pos <= pos + 1;
			hi <= hi + 32'(link_sync);
		end
		if (pos >= 56 && pos < 76) cap <= {cap[18:0], link_serial_out};
		sync_q <= link_sync;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#3ms;
		bad_count++;
		summarize();
	end
	// ***
	// test sequence
	// ***
	initial begin
		cyc(3);
		srst <= 1'b0;
		cyc(1);
		chk(32'({link_keeper_en, link_reset_n, link_sync, irq}), 32'h8);
		$display("end reset");
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].m, rows[i].e);
		end
		$display("end registers");
		wr(4'h0, 32'h0000_0003);
		cyc(2);
		chk(32'({link_keeper_en, link_reset_n}), 32'h3);
		wr(4'h5, 32'h0003_c5a9);
		wr(4'h0, 32'h0000_0002);
		clk_en = 1'b1;
		cyc(2);
		chk(32'(link_keeper_en), 32'h0);
		repeat (3) @(posedge link_sync);
		@(posedge link_bit_clk);
		#1;
		chk(frame_len, 32'd256);
		chk(hi_len, 32'd16);
		chk(32'(slot_cap), 32'h0003_c5a9);
		rc(4'h1, 32'h0000_007f, 32'h0000_006c);
		rc(4'h6, 32'h000f_ffff, 32'h0005_a3c1);
		$display("end link");
		wr(4'h0, 32'h0000_0006);
		repeat (3) @(posedge link_sync);
		@(posedge link_bit_clk);
		#1;
		rc(4'h1, 32'h0000_0040, 32'h0);
		chk(32'(slot_cap), 32'h0);
		$display("end multichannel");
		wr(4'h4, 32'h0000_0007);
		wr(4'h3, 32'h0000_0001);
		for (int i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge core_clk);
		chk(32'(irq), 32'h1);
		rc(4'h2, 32'h0000_0001, 32'h1);
		wr(4'h3, 32'h0000_0000);
		cyc(2);
		chk(32'(irq), 32'h0);
		$display("end interrupt");
		wr(4'h0, 32'h0000_0003);
		clk_en = 1'b0;
		cyc(8);
		wr(4'h4, 32'h0000_0007);
		wr(4'h3, 32'h0000_0002);
		chk(32'(link_keeper_en), 32'h1);
		wake <= 1'b1;
		cyc(4);
		wake <= 1'b0;
		cyc(4);
		chk(32'(irq), 32'h1);
		rc(4'h2, 32'h0000_0002, 32'h2);
		wr(4'h4, 32'h0000_0002);
		cyc(2);
		rc(4'h2, 32'h0000_0002, 32'h0);
		chk(32'(irq), 32'h0);
		$display("end wake");
		board_codec_disable_n <= 1'b0;
		cyc(4);
		rc(4'h1, 32'h0000_0020, 32'h0);
		$display("end strap");
		summarize();
	end
endmodule
`default_nettype wire
